// ---- shared/uart_pkg.sv ----
`default_nettype none
package uart_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IER = 4'h1;
  localparam logic [3:0] IDX_ISR = 4'h2;
  localparam logic [3:0] IDX_LCR = 4'h3;
  localparam logic [3:0] IDX_MCR = 4'h4;
  localparam logic [3:0] IDX_LSR = 4'h5;
  localparam logic [3:0] IDX_MSR = 4'h6;
  localparam logic [3:0] IDX_SPR = 4'h7;
  localparam logic [3:0] IDX_FRAC = 4'h8;

  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLH_RST = 8'h00;

  // line_control fields
  localparam int LCR_DLAB = 7;
  localparam int LCR_BRK = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_EVEN = 4;
  localparam int LCR_PEN = 3;
  localparam int LCR_STOP = 2;
  // modem_control fields
  localparam int MCR_PRESC = 7;
  localparam int MCR_LOOP = 4;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  // fifo_control fields
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  // interrupt_enable_reg fields
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;

  // interrupt_source codes
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_LS = 4'h6;
  localparam logic [3:0] ISR_RXD = 4'h4;
  localparam logic [3:0] ISR_TO = 4'hc;
  localparam logic [3:0] ISR_TX = 4'h2;

  // Timing constants and FIFO sizes; mid-bit, bit end and bit length in sampling ticks
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [3:0] BIT_END = 4'hf;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [9:0] TO_WORDS = 10'h004;
  localparam logic [9:0] TO_BITS = 10'h00c;
  localparam logic [9:0] TICKS_PER_BIT = 10'h010;
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [5:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic rx_prev;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [3:0] frac;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] fifo_control;
    logic [7:0] spr;
    logic [15:0] dcnt;
    logic [3:0] facc;
    logic [1:0] pre;
    logic [15:0][7:0] txf;
    logic [3:0] txwp;
    logic [3:0] txrp;
    logic [4:0] txc;
    tx_state_t txs;
    logic [7:0] txsh;
    logic [3:0] txt;
    logic [2:0] txb;
    logic txpar;
    logic txo;
    logic [15:0][10:0] rxf;
    logic [3:0] rxwp;
    logic [3:0] rxrp;
    logic [4:0] rxc;
    rx_state_t rxs;
    logic [7:0] rxsh;
    logic [3:0] rxt;
    logic [2:0] rxb;
    logic rxpb;
    logic ovr;
    logic txint;
    logic thre_prev;
    logic to;
    logic [9:0] toc;
    logic [31:0] rdat;
    logic pin_tx;
    logic pin_rts_n;
    logic pin_dtr_n;
    logic irq;
  } st_t;
endpackage
`default_nettype wire

// ---- core/uart_channel.sv ----
// Our own choices: register access over APB and the register addresses.
`default_nettype none
module uart_channel (
  input wire logic mclk,
  input wire logic resetn,
  input wire uart_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic carrier_detect_n,
  input wire logic ring_indicate_n,
  output logic tx_pin,
  output logic rts_n,
  output logic dtr_n,
  output logic irq
);

  uart_pkg::st_t st_ff;
  uart_pkg::st_t nxt_st;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic par_bit(input logic [7:0] l, input logic x);
    if (l[uart_pkg::LCR_STICK]) begin
      return ~l[uart_pkg::LCR_EVEN];
    end
    return l[uart_pkg::LCR_EVEN] ? x : ~x;
  endfunction

  function automatic logic [4:0] trig_lvl(input logic [1:0] t);
    case (t)
      2'h0: return uart_pkg::TRIG_1;
      2'h1: return uart_pkg::TRIG_4;
      2'h2: return uart_pkg::TRIG_8;
      default: return uart_pkg::TRIG_14;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] div;
    logic [4:0] fsum;
    logic btick;
    logic tick;
    logic [2:0] wl;
    logic fen;
    logic loop;
    logic rxl;
    logic acc;
    logic setup;
    logic [3:0] idx;
    logic dlab;
    logic [4:0] cap;
    logic tx_wr;
    logic tx_ld;
    logic rx_push;
    logic rx_pop;
    logic [7:0] rdat_al;
    logic [10:0] head;
    logic thre;
    logic temt;
    logic gerr;
    logic [3:0] code;
    logic [9:0] to_lim;
    logic [7:0] line_status;
    logic rx_end;
    logic tx_end;
    div = 16'h0000;
    fsum = 5'h00;
    btick = 1'b0;
    tick = 1'b0;
    wl = 3'h0;
    fen = 1'b0;
    loop = 1'b0;
    rxl = 1'b1;
    acc = 1'b0;
    setup = 1'b0;
    idx = 4'h0;
    dlab = 1'b0;
    cap = 5'h00;
    tx_wr = 1'b0;
    tx_ld = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rdat_al = 8'h00;
    head = 11'h000;
    thre = 1'b0;
    temt = 1'b0;
    gerr = 1'b0;
    code = uart_pkg::ISR_NONE;
    to_lim = 10'h000;
    line_status = 8'h00;
    rx_end = 1'b0;
    tx_end = 1'b0;
    nxt_st = st_ff;

    // Only the second flop's copy is ever looked at
    nxt_st.sy1 = {carrier_detect_n, ring_indicate_n, dsr_n, cts_n, rx_pin};
    nxt_st.sy2 = st_ff.sy1;

    wl = {1'b0, st_ff.line_control[1:0]} + 3'h4;
    fen = st_ff.fifo_control[uart_pkg::FCR_EN];
    loop = st_ff.modem_control[uart_pkg::MCR_LOOP];
    dlab = st_ff.line_control[uart_pkg::LCR_DLAB];
    cap = fen ? uart_pkg::FIFO_DEPTH : 5'h01;
    head = st_ff.rxf[st_ff.rxrp];

    // ---------------------------------------------------------------
    // Rate divider
    // ---------------------------------------------------------------
    // Free-running on mclk; register access never waits on a tick
    div = {st_ff.divisor_high, st_ff.dll};
    if (div == 16'h0000) begin
      div = 16'h0001;
    end
    btick = (st_ff.dcnt == 16'h0000);
    if (btick) begin
      // Carry out of the sixteenths adds one cycle to this period
      fsum = {1'b0, st_ff.facc} + {1'b0, st_ff.frac};
      nxt_st.facc = fsum[3:0];
      nxt_st.dcnt = div - 16'h0001 + {15'h0000, fsum[4]};
      nxt_st.pre = st_ff.pre + 2'h1;
    end else begin
      nxt_st.dcnt = st_ff.dcnt - 16'h0001;
    end
    tick = btick & (~st_ff.modem_control[uart_pkg::MCR_PRESC] | (&st_ff.pre));

    // ---------------------------------------------------------------
    // Transmitter
    // ---------------------------------------------------------------
    tx_end = tick & (st_ff.txt == uart_pkg::BIT_END);
    if (tick && st_ff.txs != uart_pkg::TX_IDLE) begin
      nxt_st.txt = st_ff.txt + 4'h1;
    end
    case (st_ff.txs)
      uart_pkg::TX_IDLE: begin
        nxt_st.txo = 1'b1;
        if (tick && st_ff.txc != 5'h00) begin
          tx_ld = 1'b1;
          nxt_st.txsh = st_ff.txf[st_ff.txrp];
          nxt_st.txrp = st_ff.txrp + 4'h1;
          nxt_st.txs = uart_pkg::TX_START;
          nxt_st.txt = 4'h0;
          nxt_st.txo = 1'b0;
        end
      end
      uart_pkg::TX_START: begin
        if (tx_end) begin
          nxt_st.txs = uart_pkg::TX_DATA;
          nxt_st.txb = 3'h0;
          nxt_st.txo = st_ff.txsh[0];
          nxt_st.txpar = st_ff.txsh[0];
        end
      end
      uart_pkg::TX_DATA: begin
        if (tx_end) begin
          if (st_ff.txb == wl) begin
            if (st_ff.line_control[uart_pkg::LCR_PEN]) begin
              nxt_st.txs = uart_pkg::TX_PAR;
              nxt_st.txo = par_bit(st_ff.line_control, st_ff.txpar);
            end else begin
              nxt_st.txs = uart_pkg::TX_STOP;
              nxt_st.txo = 1'b1;
            end
            nxt_st.txb = 3'h0;
          end else begin
            nxt_st.txb = st_ff.txb + 3'h1;
            nxt_st.txsh = {1'b0, st_ff.txsh[7:1]};
            nxt_st.txo = st_ff.txsh[1];
            nxt_st.txpar = st_ff.txpar ^ st_ff.txsh[1];
          end
        end
      end
      uart_pkg::TX_PAR: begin
        if (tx_end) begin
          nxt_st.txs = uart_pkg::TX_STOP;
          nxt_st.txo = 1'b1;
        end
      end
      uart_pkg::TX_STOP: begin
        if (tx_end) begin
          if (st_ff.txb == 3'h0 && st_ff.line_control[uart_pkg::LCR_STOP]) begin
            nxt_st.txb = 3'h1;
          end else begin
            nxt_st.txs = uart_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        nxt_st.txs = uart_pkg::TX_IDLE;
      end
    endcase

    // ---------------------------------------------------------------
    // Receiver
    // ---------------------------------------------------------------
    rxl = loop ? st_ff.txo : st_ff.sy2[0];
    nxt_st.rx_prev = rxl;
    rx_end = tick & (st_ff.rxt == uart_pkg::BIT_END);
    if (tick && st_ff.rxs != uart_pkg::RX_IDLE) begin
      nxt_st.rxt = st_ff.rxt + 4'h1;
    end
    rdat_al = st_ff.rxsh >> (3'h7 - wl);
    case (st_ff.rxs)
      uart_pkg::RX_IDLE: begin
        if (st_ff.rx_prev && !rxl) begin
          nxt_st.rxs = uart_pkg::RX_START;
          nxt_st.rxt = 4'h0;
        end
      end
      uart_pkg::RX_START: begin
        if (tick && st_ff.rxt == uart_pkg::START_MID) begin
          // A glitch that is gone by mid-bit is dropped
          nxt_st.rxs = rxl ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          nxt_st.rxt = 4'h0;
          nxt_st.rxb = 3'h0;
        end
      end
      uart_pkg::RX_DATA: begin
        if (rx_end) begin
          nxt_st.rxsh = {rxl, st_ff.rxsh[7:1]};
          if (st_ff.rxb == wl) begin
            nxt_st.rxs = st_ff.line_control[uart_pkg::LCR_PEN] ?
                         uart_pkg::RX_PAR : uart_pkg::RX_STOP;
          end else begin
            nxt_st.rxb = st_ff.rxb + 3'h1;
          end
        end
      end
      uart_pkg::RX_PAR: begin
        if (rx_end) begin
          nxt_st.rxpb = rxl;
          nxt_st.rxs = uart_pkg::RX_STOP;
        end
      end
      uart_pkg::RX_STOP: begin
        if (rx_end) begin
          nxt_st.rxs = uart_pkg::RX_IDLE;
          if (st_ff.rxc >= cap) begin
            nxt_st.ovr = 1'b1;
          end else begin
            rx_push = 1'b1;
            // Tags: break, framing, parity above the data byte
            nxt_st.rxf[st_ff.rxwp] = {
              ~rxl & (rdat_al == 8'h00) &
                ~(st_ff.line_control[uart_pkg::LCR_PEN] & st_ff.rxpb),
              ~rxl,
              st_ff.line_control[uart_pkg::LCR_PEN] &
                (st_ff.rxpb != par_bit(st_ff.line_control, ^rdat_al)),
              rdat_al};
            nxt_st.rxwp = st_ff.rxwp + 4'h1;
          end
        end
      end
      default: begin
        nxt_st.rxs = uart_pkg::RX_IDLE;
      end
    endcase

    // ---------------------------------------------------------------
    // Status and interrupt source
    // ---------------------------------------------------------------
    thre = (st_ff.txc == 5'h00);
    temt = thre & (st_ff.txs == uart_pkg::TX_IDLE);
    gerr = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < st_ff.rxc) begin
        gerr = gerr | (|st_ff.rxf[4'(st_ff.rxrp + 4'(i))][10:8]);
      end
    end
    line_status = {fen & gerr, temt, thre,
           (st_ff.rxc != 5'h00) ? head[10:8] : 3'h0,
           st_ff.ovr, st_ff.rxc != 5'h00};

    to_lim = (({7'h00, wl} + 10'h001) * uart_pkg::TO_WORDS +
              uart_pkg::TO_BITS) * uart_pkg::TICKS_PER_BIT;
    if (st_ff.interrupt_enable_reg[uart_pkg::IER_LS] && (st_ff.ovr || (|line_status[4:2]))) begin
      code = uart_pkg::ISR_LS;
    end else if (st_ff.interrupt_enable_reg[uart_pkg::IER_RX] &&
                 (fen ? st_ff.rxc >= trig_lvl(st_ff.fifo_control[7:6])
                      : st_ff.rxc != 5'h00)) begin
      code = uart_pkg::ISR_RXD;
    end else if (st_ff.interrupt_enable_reg[uart_pkg::IER_RX] && st_ff.to) begin
      code = uart_pkg::ISR_TO;
    end else if (st_ff.interrupt_enable_reg[uart_pkg::IER_TX] && st_ff.txint) begin
      code = uart_pkg::ISR_TX;
    end

    // ---------------------------------------------------------------
    // Register access
    // ---------------------------------------------------------------
    setup = apb_req.psel & ~apb_req.penable;
    acc = apb_req.psel & apb_req.penable;
    idx = apb_req.paddr[5:2];
    if (setup) begin
      case (idx)
        uart_pkg::IDX_DATA: nxt_st.rdat = {24'h0,
                              dlab ? st_ff.dll : head[7:0]};
        uart_pkg::IDX_IER: nxt_st.rdat = {24'h0, dlab ? st_ff.divisor_high : st_ff.interrupt_enable_reg};
        uart_pkg::IDX_ISR: nxt_st.rdat = {24'h0, fen, fen, 2'h0, code};
        uart_pkg::IDX_LCR: nxt_st.rdat = {24'h0, st_ff.line_control};
        uart_pkg::IDX_MCR: nxt_st.rdat = {24'h0, st_ff.modem_control};
        uart_pkg::IDX_LSR: nxt_st.rdat = {24'h0, line_status};
        // Modem inputs read as idle while looped back
        uart_pkg::IDX_MSR: nxt_st.rdat = {24'h0,
                             loop ? 4'h0 : ~st_ff.sy2[4:1], 4'h0};
        uart_pkg::IDX_SPR: nxt_st.rdat = {24'h0, st_ff.spr};
        uart_pkg::IDX_FRAC: nxt_st.rdat = {28'h0, st_ff.frac};
        default: nxt_st.rdat = 32'h0;
      endcase
    end

    if (acc && apb_req.pwrite) begin
      case (idx)
        uart_pkg::IDX_DATA: begin
          if (dlab) begin
            nxt_st.dll = apb_req.pwdata[7:0];
          end else if (st_ff.txc < cap) begin
            tx_wr = 1'b1;
            nxt_st.txf[st_ff.txwp] = apb_req.pwdata[7:0];
            nxt_st.txwp = st_ff.txwp + 4'h1;
          end
        end
        uart_pkg::IDX_IER: begin
          if (dlab) begin
            nxt_st.divisor_high = apb_req.pwdata[7:0];
          end else begin
            nxt_st.interrupt_enable_reg = {4'h0, apb_req.pwdata[3:0]};
          end
        end
        uart_pkg::IDX_ISR: nxt_st.fifo_control = {apb_req.pwdata[7:6], 5'h00,
                                        apb_req.pwdata[uart_pkg::FCR_EN]};
        uart_pkg::IDX_LCR: nxt_st.line_control = apb_req.pwdata[7:0];
        uart_pkg::IDX_MCR: nxt_st.modem_control = {apb_req.pwdata[7], 2'h0,
                                        apb_req.pwdata[4:0]};
        uart_pkg::IDX_SPR: nxt_st.spr = apb_req.pwdata[7:0];
        uart_pkg::IDX_FRAC: nxt_st.frac = apb_req.pwdata[3:0];
        default: begin
        end
      endcase
    end
    if (acc && !apb_req.pwrite && !dlab && idx == uart_pkg::IDX_DATA &&
        st_ff.rxc != 5'h00) begin
      rx_pop = 1'b1;
      nxt_st.rxrp = st_ff.rxrp + 4'h1;
    end

    // Event set wins over a clearing read in the same cycle
    nxt_st.ovr = nxt_st.ovr | (st_ff.ovr & ~(acc & ~apb_req.pwrite &
                 idx == uart_pkg::IDX_LSR));
    if (acc && !apb_req.pwrite && idx == uart_pkg::IDX_LSR) begin
      nxt_st.ovr = (st_ff.rxs == uart_pkg::RX_STOP) & rx_end &
                   (st_ff.rxc >= cap);
    end
    nxt_st.thre_prev = thre;
    nxt_st.txint = (thre & ~st_ff.thre_prev) | (st_ff.txint & ~tx_wr &
                   ~(acc & ~apb_req.pwrite & idx == uart_pkg::IDX_ISR &
                     code == uart_pkg::ISR_TX));

    nxt_st.txc = st_ff.txc + {4'h0, tx_wr} - {4'h0, tx_ld};
    nxt_st.rxc = st_ff.rxc + {4'h0, rx_push} - {4'h0, rx_pop};

    // Time-out counts ticks while unread data sits idle
    if (st_ff.rxc == 5'h00 || rx_push || rx_pop) begin
      nxt_st.toc = 10'h000;
      nxt_st.to = 1'b0;
    end else if (tick && !st_ff.to) begin
      nxt_st.toc = st_ff.toc + 10'h001;
      nxt_st.to = (st_ff.toc + 10'h001 >= to_lim);
    end

    // Queue flushes; toggling the enable flushes both
    if (acc && apb_req.pwrite && idx == uart_pkg::IDX_ISR) begin
      if (apb_req.pwdata[uart_pkg::FCR_RXRST] ||
          apb_req.pwdata[uart_pkg::FCR_EN] != fen) begin
        nxt_st.rxwp = 4'h0;
        nxt_st.rxrp = 4'h0;
        nxt_st.rxc = 5'h00;
      end
      if (apb_req.pwdata[uart_pkg::FCR_TXRST] ||
          apb_req.pwdata[uart_pkg::FCR_EN] != fen) begin
        nxt_st.txwp = 4'h0;
        nxt_st.txrp = 4'h0;
        nxt_st.txc = 5'h00;
      end
    end

    // ---------------------------------------------------------------
    // Pins
    // ---------------------------------------------------------------
    nxt_st.pin_tx = nxt_st.modem_control[uart_pkg::MCR_LOOP] |
                    (nxt_st.txo & ~nxt_st.line_control[uart_pkg::LCR_BRK]);
    nxt_st.pin_rts_n = nxt_st.modem_control[uart_pkg::MCR_LOOP] |
                       ~nxt_st.modem_control[uart_pkg::MCR_RTS];
    nxt_st.pin_dtr_n = nxt_st.modem_control[uart_pkg::MCR_LOOP] |
                       ~nxt_st.modem_control[uart_pkg::MCR_DTR];
    nxt_st.irq = st_ff.modem_control[uart_pkg::MCR_OUT2] &
                 (code != uart_pkg::ISR_NONE);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.dll <= uart_pkg::DLL_RST;
      st_ff.divisor_high <= uart_pkg::DLH_RST;
      st_ff.sy1 <= 5'h1f;
      st_ff.sy2 <= 5'h1f;
      st_ff.rx_prev <= 1'b1;
      st_ff.txo <= 1'b1;
      st_ff.thre_prev <= 1'b1;
      st_ff.pin_tx <= 1'b1;
      st_ff.pin_rts_n <= 1'b1;
      st_ff.pin_dtr_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdat;
  assign pready = 1'b1;
  assign pslverr = apb_req.psel & apb_req.penable &
                   (apb_req.paddr[5:2] > uart_pkg::IDX_FRAC);
  assign tx_pin = st_ff.pin_tx;
  assign rts_n = st_ff.pin_rts_n;
  assign dtr_n = st_ff.pin_dtr_n;
  assign irq = st_ff.irq;

endmodule
`default_nettype wire

// ---- bench/uart_remote.sv ----
`default_nettype none
module uart_remote (
  input wire logic mclk,
  input wire logic tx_pin,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------
  // Far-end serial device, 8 data bits
  // ------------------------------------
  int cpb = 16;
  bit pen = 1'b0;
  logic [7:0] got_q[$];
  // Line rests at mark between frames and through loopback
  initial rx_pin = 1'b1;
  task automatic send(input logic [7:0] b, input bit bad);
    logic [10:0] f;
    f = pen ? {1'b1, ^b ^ bad, b, 1'b0} : {2'b11, b, 1'b0};
    for (int i = 0; i < (pen ? 11 : 10); i++) begin
      rx_pin <= f[i];
      repeat (cpb) @(posedge mclk);
    end
  endtask
  task automatic pulse(input int n);
    rx_pin <= 1'b0;
    repeat (n) @(posedge mclk);
    rx_pin <= 1'b1;
  endtask
  // Mid-bit sampling; a bad stop drops the byte so the count shows it
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge tx_pin);
      repeat (cpb / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (cpb) @(posedge mclk);
        d[i] = tx_pin;
      end
      repeat (pen ? 2 * cpb : cpb) @(posedge mclk);
      if (tx_pin) got_q.push_back(d);
    end
  end
endmodule
`default_nettype wire

// ---- bench/uart_channel_assertions.sv ----
`default_nettype none
module uart_channel_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire uart_pkg::apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_pin,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic irq
);
  // ------------------------------------
  // Shadow of modem_control, low-run count
  // ------------------------------------
  logic [7:0] mcr_ff;
  logic [7:0] run_ff;
  logic acc;
  logic wr_mcr;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr_mcr = acc && apb_req.pwrite
    && apb_req.paddr[5:2] == uart_pkg::IDX_MCR;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mcr_ff <= 8'h00;
      run_ff <= 8'h00;
    end else begin
      if (wr_mcr) mcr_ff <= apb_req.pwdata[7:0];
      if (tx_pin) run_ff <= 8'h00;
      else if (run_ff != 8'hff) run_ff <= run_ff + 8'h01;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_access;
    acc;
  endsequence
  sequence s_bad_index;
    apb_req.paddr[5:2] > uart_pkg::IDX_FRAC;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_reset_idle: assert property ($rose(resetn) |-> tx_pin && rts_n
    && dtr_n && !irq) else $error("outputs not idle after reset");
  a_index_refused: assert property (s_access ##0 s_bad_index
    |-> pslverr && prdata == 32'h0) else $error("bad index accepted");
  a_error_cause: assert property (pslverr |-> acc
    && apb_req.paddr[5:2] > 4'h8) else $error("stray pslverr");
  // Fractional ticks only lengthen, so no bit is shorter than 16 mclk
  a_bit_width: assert property ($rose(tx_pin) |-> run_ff >= 8'h10)
    else $error("low bit too short");
  a_loop_mark: assert property (mcr_ff[4] && $past(mcr_ff[4])
    |-> tx_pin && rts_n && dtr_n) else $error("loopback pins active");
  a_modem_follow: assert property (!mcr_ff[4] && $stable(mcr_ff)
    |-> rts_n == !mcr_ff[1] && dtr_n == !mcr_ff[0])
    else $error("modem outputs wrong");
  a_irq_gate: assert property (!mcr_ff[3] && $stable(mcr_ff) |-> !irq)
    else $error("irq while output disabled");
endmodule
bind uart_channel uart_channel_checker chk_u (.mclk(mclk), .resetn(resetn),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n), .irq(irq));
`default_nettype wire

// ---- bench/uart_channel_baud_tx_rx_loopback_tb.sv ----
`default_nettype none
module uart_channel_baud_tx_rx_loopback_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  uart_pkg::apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_pin, tx_pin, rts_n, dtr_n, irq;
  logic [3:0] mdm = 4'hf;
  logic [31:0] seed = 32'hab94;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  logic [7:0] rxq[$];
  initial forever #5 mclk = ~mclk;
  uart_channel dut_u (.mclk(mclk), .resetn(resetn), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .cts_n(mdm[0]), .dsr_n(mdm[1]), .carrier_detect_n(mdm[2]),
    .ring_indicate_n(mdm[3]), .tx_pin(tx_pin), .rts_n(rts_n),
    .dtr_n(dtr_n), .irq(irq));
  uart_remote rem_u (.mclk(mclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
  // ------------------------------------
  // Reporting, stimulus source, bus cycles
  // ------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // One idle edge after release keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [3:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata[7:0];
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [3:0] i, output logic [7:0] q);
    apb(1'b0, i, 8'h00, q);
  endtask
  task automatic tx_bytes(input int n);
    logic [7:0] q;
    for (int i = 0; i < n; i++) begin
      q = rnd();
      exp_q.push_back(q);
      wr(uart_pkg::IDX_DATA, q);
    end
    rd(uart_pkg::IDX_LSR, q);
    if (n > 0) check({6'h0, q[6:5]}, 8'h00);
    while (rem_u.got_q.size() < exp_q.size()) @(posedge mclk);
    while (exp_q.size() > 0) begin
      check(rem_u.got_q.pop_front(), exp_q.pop_front());
    end
    repeat (2 * rem_u.cpb) @(posedge mclk);
    rd(uart_pkg::IDX_LSR, q);
    check({6'h0, q[6:5]}, 8'h03);
  endtask
  task automatic rx_send(input int n, input bit bad);
    logic [7:0] q;
    for (int i = 0; i < n; i++) begin
      q = rnd();
      rxq.push_back(q);
      rem_u.send(q, bad && i == 0);
    end
    repeat (rem_u.cpb) @(posedge mclk);
  endtask
  task automatic rx_drain(input int n, input bit bad);
    logic [7:0] q;
    for (int i = 0; i < n; i++) begin
      rd(uart_pkg::IDX_LSR, q);
      check({4'h0, q[4:2], q[0]}, {6'h0, bad && i == 0, 1'b1});
      rd(uart_pkg::IDX_DATA, q);
      check(q, rxq.pop_front());
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial begin
    logic [7:0] q;
    logic [7:0] b;
    int dl;
    int fr;
    int ps;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    wr(uart_pkg::IDX_LCR, 8'h83);
    rd(uart_pkg::IDX_DATA, q);
    check(q, uart_pkg::DLL_RST);
    rd(uart_pkg::IDX_IER, q);
    check(q, uart_pkg::DLH_RST);
    wr(uart_pkg::IDX_DATA, 8'h80);
    wr(uart_pkg::IDX_IER, 8'h01);
    rd(uart_pkg::IDX_DATA, q);
    check(q, 8'h80);
    rd(uart_pkg::IDX_IER, q);
    check(q, 8'h01);
    rd(4'hc, q);
    check(q, 8'h00);
    wr(uart_pkg::IDX_ISR, 8'h01);
    for (int k = 0; k < 4; k++) begin
      dl = (k < 2) ? 2 : 1;
      fr = (k == 1) ? 8 : 0;
      ps = (k == 2) ? 1 : 0;
      wr(uart_pkg::IDX_LCR, 8'h83);
      wr(uart_pkg::IDX_DATA, dl[7:0]);
      wr(uart_pkg::IDX_IER, 8'h00);
      wr(uart_pkg::IDX_FRAC, fr[7:0]);
      wr(uart_pkg::IDX_LCR, 8'h03);
      wr(uart_pkg::IDX_MCR, {ps[0], 7'h00});
      rem_u.cpb = (dl * 16 + fr) * (ps == 1 ? 4 : 1);
      tx_bytes(k == 3 ? 16 : 2);
      rx_send(1, 1'b0);
      rx_drain(1, 1'b0);
    end
    rem_u.pulse(4);
    repeat (300) @(posedge mclk);
    rd(uart_pkg::IDX_LSR, q);
    check({7'h0, q[0]}, 8'h00);
    wr(uart_pkg::IDX_LCR, 8'h1b);
    rem_u.pen = 1'b1;
    rx_send(2, 1'b1);
    rx_drain(2, 1'b1);
    wr(uart_pkg::IDX_ISR, 8'h41);
    wr(uart_pkg::IDX_IER, 8'h01);
    wr(uart_pkg::IDX_MCR, 8'h08);
    rx_send(3, 1'b0);
    rd(uart_pkg::IDX_ISR, q);
    check({4'h0, q[3:0]}, {4'h0, uart_pkg::ISR_NONE});
    rx_send(1, 1'b0);
    rd(uart_pkg::IDX_ISR, q);
    check({3'h0, irq, q[3:0]}, {4'h1, uart_pkg::ISR_RXD});
    rx_drain(4, 1'b0);
    rx_send(1, 1'b0);
    rd(uart_pkg::IDX_ISR, q);
    check({4'h0, q[3:0]}, {4'h0, uart_pkg::ISR_NONE});
    repeat (1000) @(posedge mclk);
    rd(uart_pkg::IDX_ISR, q);
    check({4'h0, q[3:0]}, {4'h0, uart_pkg::ISR_TO});
    rx_drain(1, 1'b0);
    wr(uart_pkg::IDX_LCR, 8'h03);
    rem_u.pen = 1'b0;
    wr(uart_pkg::IDX_ISR, 8'h00);
    wr(uart_pkg::IDX_IER, 8'h02);
    for (int i = 0; i < 2; i++) begin
      b = rnd();
      exp_q.push_back(b);
      wr(uart_pkg::IDX_DATA, b);
    end
    rd(uart_pkg::IDX_LSR, q);
    check({6'h0, q[6:5]}, 8'h00);
    while (rem_u.got_q.size() < 1) @(posedge mclk);
    repeat (rem_u.cpb) @(posedge mclk);
    rd(uart_pkg::IDX_LSR, q);
    check({6'h0, q[6:5]}, 8'h01);
    rd(uart_pkg::IDX_ISR, q);
    check({3'h0, irq, q[3:0]}, {4'h1, uart_pkg::ISR_TX});
    tx_bytes(0);
    wr(uart_pkg::IDX_ISR, 8'h01);
    // Seven data bits, two stops: only the loopback sees this format
    wr(uart_pkg::IDX_LCR, 8'h06);
    wr(uart_pkg::IDX_MCR, 8'h18);
    b = rnd();
    mdm <= b[3:0];
    b = rnd();
    wr(uart_pkg::IDX_DATA, b);
    do rd(uart_pkg::IDX_LSR, q); while (q[0] !== 1'b1);
    check({5'h0, tx_pin, rts_n, dtr_n}, 8'h07);
    rd(uart_pkg::IDX_MSR, q);
    check(q, 8'h00);
    rd(uart_pkg::IDX_DATA, q);
    check(q, b & 8'h7f);
    repeat (2 * rem_u.cpb) @(posedge mclk);
    wr(uart_pkg::IDX_MCR, 8'h03);
    check({7'h0, rem_u.got_q.size() == 0}, 8'h01);
    check({6'h0, rts_n, dtr_n}, 8'h00);
    rd(uart_pkg::IDX_MSR, q);
    check(q, {~mdm[2], ~mdm[3], ~mdm[1], ~mdm[0], 4'h0});
    tally_and_finish();
  end
endmodule
`default_nettype wire
